/* File: stp_regs.vh */
// Purpose: Constants for the serial terminal port
// Assumes: System clock of 10 MHz
// Notes:   Times in microseconds, counts derived
`ifndef STP_REGS_VH
`define STP_REGS_VH
// ==========================================================
// Addressing and framing
`define STP_DEV_NUM      8'h02
`define STP_CMD_WR_BIT   4
`define STP_CMD_RD_BIT   5
`define STP_FRAME_LOAD   4'h5
`define STP_SR_W         11
`define STP_BYTE_POS     2
// ==========================================================
// Status byte fields
`define STP_ST_ERR       0
`define STP_ST_BRK       2
`define STP_ST_BSY       4
`define STP_ST_EX        5
`define STP_ST_DU        7
// ==========================================================
// Command byte fields
`define STP_CM_DIS       0
`define STP_CM_ENB       1
`define STP_CM_UNBLK     2
`define STP_CM_BLK       3
// ==========================================================
// Timing
`define STP_CLK_KHZ      10000
`define STP_BASE_US      2270
`define STP_HALF_US      4500
`define STP_BASE_CYC     ((`STP_BASE_US * `STP_CLK_KHZ) / 1000)
`define STP_HALF_CYC     ((`STP_HALF_US * `STP_CLK_KHZ) / 1000)
`define STP_TICK_DIV     4
`endif

/* File: stp_sync.v */
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to CLK
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
module stp_sync
#(
  parameter W   = 1,
  parameter RST = 1'b1
)
(
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;
  // ==========================================================
  // Double flop
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= {W{RST}};
      q      <= {W{RST}};
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // stp_sync

/* File: stp_bitclk.v */
// Purpose: Base tick and bit tick generator
// Assumes: run high while timing is active
// Notes:   In receive, first bit tick after first_cyc, then each period
`timescale 1ns/1ps
module stp_bitclk
#(
  parameter BASE_CYC = 22700,
  parameter FIRST_CYC = 45000,
  parameter DIV      = 4
)
(
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  input  wire run,
  input  wire rx_mode,
  output reg  bit_tick
);
  reg [15:0] base_cnt_r;
  reg [2:0]  div_r;
  reg        first_r;
  wire       base_tick;
  // Mid-bit delay reached via first period only in receive
  assign base_tick = (base_cnt_r == 16'h0000);
  // ==========================================================
  // Divide chain, restarts when idle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_cnt_r <= 16'h0000;
      div_r      <= 3'h0;
      first_r    <= 1'b0;
      bit_tick   <= 1'b0;
    end
    else if (ce)
    begin
      bit_tick <= 1'b0;
      if (!run)
      begin
        base_cnt_r <= 16'hFFFF;
        first_r    <= 1'b1;
        div_r      <= 3'h0;
      end
      else if (first_r && rx_mode)
      begin
        // Half-bit delay for mid-bit sampling
        if (base_cnt_r == 16'hFFFF)
          base_cnt_r <= FIRST_CYC[15:0] - 16'h0001;
        else if (base_tick)
        begin
          first_r    <= 1'b0;
          bit_tick   <= 1'b1;
          base_cnt_r <= BASE_CYC[15:0] - 16'h0001;
        end
        else
          base_cnt_r <= base_cnt_r - 16'h0001;
      end
      else
      begin
        first_r <= 1'b0;
        if (base_cnt_r == 16'hFFFF || base_tick)
        begin
          base_cnt_r <= BASE_CYC[15:0] - 16'h0001;
          if (base_cnt_r != 16'hFFFF)
          begin
            if (div_r == DIV[2:0] - 3'h1)
            begin
              div_r    <= 3'h0;
              bit_tick <= 1'b1;
            end
            else
              div_r <= div_r + 3'h1;
          end
        end
        else
          base_cnt_r <= base_cnt_r - 16'h0001;
      end
    end
  end
endmodule // stp_bitclk

/* File: stp_top.v */
// Purpose: Serial terminal port controller on a byte I/O bus
// Assumes: Bus strobes are asynchronous pins, synchronised here
// Notes:   Strobes act on edges seen after synchronisation
// Function
// - Select latch set on own device number
// - Command bit 12 selects write mode
// - Data strobe loads counter, frame, shifter
// - Strobe release sets timing active
// - Base tick 2.27 ms, bit tick 9.08 ms
// - Tick increments counter, shifts unless full
// - Transmit line is gated shifter bit
// - Counter carry clears timing active
// - Write mode busy while timing active
// - Reset or bit 13 selects read mode
// - Receive start edge arms, mid-bit sampling
// - Ten samples, carry loads byte buffer
// - Read busy until byte buffered
// - Unread byte overwritten sets overrun
// - Block command stops echo
// - Missing stop bit raises break
// - Unavailable follows terminal sense input
// - Status byte bit layout
// - Command byte bit decoding
// - Arm, attention and interrupt request
// - Acknowledge chain claim or pass
`timescale 1ns/1ps
`include "stp_regs.vh"
module stp_top
#(
  parameter BASE_CYC  = `STP_BASE_CYC,
  parameter FIRST_CYC = `STP_HALF_CYC
)
(
  input  wire       CLK_SYS,
  input  wire       RST_N,
  input  wire       CE,
  input  wire [7:0] BUS_DATA_IN,
  output reg  [7:0] BUS_DATA_OUT,
  output wire       BUS_DATA_OE,
  input  wire       ADDRESS_STROBE_LINE,
  input  wire       DATA_AVAILABLE_STROBE,
  input  wire       DATA_REQUEST,
  input  wire       STATUS_REQUEST,
  input  wire       OUTPUT_COMMAND_LINE,
  input  wire       CMD_WRITE_BIT12,
  input  wire       CMD_READ_BIT13,
  input  wire       SERIAL_RECEIVE_LINE,
  output wire       SERIAL_TRANSMIT_LINE,
  input  wire       TERMINAL_OFFLINE,
  output wire       INTERRUPT_REQUEST_N,
  input  wire       ACK_CHAIN_IN_N,
  output wire       ACK_CHAIN_OUT_N,
  output wire       ACK_SYNC_N
);
  // ==========================================================
  // Synchronised pins
  wire [7:0] dat_s;
  wire       address_strobe_line_s, da_s, dr_s, sr_s, cmd_s, b12_s, b13_s, rx_s, off_s;
  wire       ack_n_s;
  stp_sync #(.W(8), .RST(1'b0)) u_sd
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .ce    (CE),
    .d     (BUS_DATA_IN),
    .q     (dat_s)
  );
  stp_sync #(.W(10), .RST(1'b0)) u_sc
  (
    .clk   (CLK_SYS),
    .rst_n (RST_N),
    .ce    (CE),
    .d     ({ADDRESS_STROBE_LINE, DATA_AVAILABLE_STROBE, DATA_REQUEST,
             STATUS_REQUEST, OUTPUT_COMMAND_LINE, CMD_WRITE_BIT12,
             CMD_READ_BIT13, ~SERIAL_RECEIVE_LINE, TERMINAL_OFFLINE,
             ~ACK_CHAIN_IN_N}),
    .q     ({address_strobe_line_s, da_s, dr_s, sr_s, cmd_s, b12_s, b13_s, rx_s, off_s,
             ack_n_s})
  );
  wire rxd = ~rx_s;   // Idle high receive line
  wire ack = ack_n_s; // Acknowledge asserted
  // ==========================================================
  // Previous levels for edge detection
  // Reset levels equal the idle pin levels: no false edge
  reg address_strobe_line_d_r, da_d_r, dr_d_r, cmd_d_r, rxd_d_r, bsy_d_r, ack_d_r;
  wire busy_indication;
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      address_strobe_line_d_r <= 1'b0;
      da_d_r   <= 1'b0;
      dr_d_r   <= 1'b0;
      cmd_d_r  <= 1'b0;
      rxd_d_r  <= 1'b1;
      bsy_d_r  <= 1'b1;
      ack_d_r  <= 1'b0;
    end
    else if (CE)
    begin
      address_strobe_line_d_r <= address_strobe_line_s;
      da_d_r   <= da_s;
      dr_d_r   <= dr_s;
      cmd_d_r  <= cmd_s;
      rxd_d_r  <= rxd;
      bsy_d_r  <= busy_indication;
      ack_d_r  <= ack;
    end
  end
  // ==========================================================
  // Selection latch and gated strobes
  reg  sel_r;
  wire address_strobe_line_fall  = address_strobe_line_d_r & ~address_strobe_line_s;
  wire sel_hit    = (dat_s == `STP_DEV_NUM);
  // Select taken on strobe trailing edge
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      sel_r <= 1'b0;
    else if (CE && address_strobe_line_fall)
      sel_r <= sel_hit;
  end
  wire transmit_load_pulse = sel_r & da_s & ~da_d_r;
  wire da_release          = sel_r & ~da_s & da_d_r;
  wire gated_data_request  = sel_r & dr_s & ~dr_d_r;
  wire cmd_pulse           = sel_r & cmd_s & ~cmd_d_r;
  wire rx_start            = rxd_d_r & ~rxd;
  // ==========================================================
  // Core state
  reg        read_mode_latch_r, timing_active_latch_r, ready_r;
  reg  [3:0] frame_cnt_r;
  reg  [`STP_SR_W-1:0] shift_r;
  reg  [7:0] byte_buf_r;
  reg        buf_full_r, err_r, break_flag_r, no_echo_latch_r;
  reg        arm_r, attn_r, interrupt_enable_latch_r;
  wire       bit_tick;
  wire       write_mode = ~read_mode_latch_r;
  wire       frame_counter_carry = bit_tick & (frame_cnt_r == 4'hF);
  wire       buffer_load_pulse = frame_counter_carry & read_mode_latch_r;
  wire       rx_arm = read_mode_latch_r & ~timing_active_latch_r &
                      rx_start;
  // Command byte decode
  wire cm_dis = cmd_pulse & dat_s[`STP_CM_DIS];
  wire cm_enb = cmd_pulse & dat_s[`STP_CM_ENB];
  wire cm_disarm = cm_dis & cm_enb;
  // Write select on bit 12 / command write, read on bit 13 / command read
  wire go_write = cmd_pulse & (b12_s | dat_s[`STP_CMD_WR_BIT]);
  wire go_read  = cmd_pulse & (b13_s | dat_s[`STP_CMD_RD_BIT]);
  stp_bitclk #(
    .BASE_CYC  (BASE_CYC),
    .FIRST_CYC (FIRST_CYC),
    .DIV       (`STP_TICK_DIV)
  ) u_clk
  (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .ce       (CE),
    .run      (timing_active_latch_r),
    .rx_mode  (read_mode_latch_r),
    .bit_tick (bit_tick)
  );
  // ==========================================================
  // Mode, timing and framing
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      read_mode_latch_r     <= 1'b1;  // Initialize selects read
      timing_active_latch_r <= 1'b0;
      ready_r               <= 1'b1;
      frame_cnt_r           <= 4'h0;
      shift_r               <= {`STP_SR_W{1'b1}};
    end
    else if (CE)
    begin
      if (go_read)
        read_mode_latch_r <= 1'b1;
      else if (go_write)
        read_mode_latch_r <= 1'b0;
      if (write_mode && transmit_load_pulse)
      begin
        // Stops high, start low, data between
        frame_cnt_r <= `STP_FRAME_LOAD;
        ready_r     <= 1'b0;
        shift_r     <= {2'b11, dat_s, 1'b0};
      end
      else if (rx_arm)
      begin
        // Start edge arms the receiver
        timing_active_latch_r <= 1'b1;
        ready_r               <= 1'b0;
        frame_cnt_r           <= `STP_FRAME_LOAD;
      end
      else if (write_mode && da_release)
        timing_active_latch_r <= 1'b1;
      else if (bit_tick && timing_active_latch_r)
      begin
        frame_cnt_r <= frame_cnt_r + 4'h1;
        if (frame_counter_carry)
        begin
          timing_active_latch_r <= 1'b0;
          if (read_mode_latch_r)
            ready_r <= rxd;
          else
            ready_r <= 1'b1;
        end
        else if (read_mode_latch_r)
          // Samples enter at the top, so the start bit ends at bit 1, below the data
          shift_r <= {rxd, shift_r[`STP_SR_W-1:1]};
        else
          shift_r <= {1'b1, shift_r[`STP_SR_W-1:1]};
      end
    end
  end
  // ==========================================================
  // Byte buffer, busy and error flags
  // Start bit sits just below the data once ten samples are in
  wire [7:0] rx_byte = shift_r[`STP_BYTE_POS+7:`STP_BYTE_POS];
  // One cycle after a receive carry, ready holds the stop sample
  reg        rx_end_r;
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      byte_buf_r   <= 8'h00;
      buf_full_r   <= 1'b0;
      err_r        <= 1'b0;
      break_flag_r <= 1'b0;
      rx_end_r     <= 1'b0;
    end
    else if (CE)
    begin
      rx_end_r <= buffer_load_pulse;
      if (buffer_load_pulse)
      begin
        byte_buf_r <= rx_byte;
        buf_full_r <= 1'b1;
        if (buf_full_r)
          err_r <= 1'b1;
      end
      else if (gated_data_request)
        buf_full_r <= 1'b0;
      // Command clears error flags; a coincident set wins
      if (cmd_pulse && !buffer_load_pulse)
        err_r <= 1'b0;
      // Timing ended with ready still low: no stop bit seen
      if (rx_end_r && !ready_r)
        break_flag_r <= 1'b1;
      else if (cmd_pulse)
        break_flag_r <= 1'b0;
    end
  end
  // Busy differs by mode
  assign busy_indication = read_mode_latch_r ? ~buf_full_r
                                             : timing_active_latch_r;
  // ==========================================================
  // Acknowledge claim, decoded ahead of the latches that use it
  wire ack_fall  = ack & ~ack_d_r;
  wire ack_mine  = attn_r & interrupt_enable_latch_r;
  wire ack_claim = ack_fall & ack_mine;
  // ==========================================================
  // Echo and interrupt latches
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      no_echo_latch_r          <= 1'b0;
      arm_r                    <= 1'b0;
      attn_r                   <= 1'b0;
      interrupt_enable_latch_r <= 1'b0;
    end
    else if (CE)
    begin
      if (cmd_pulse && dat_s[`STP_CM_BLK])
        no_echo_latch_r <= 1'b1;
      else if (cmd_pulse && dat_s[`STP_CM_UNBLK])
        no_echo_latch_r <= 1'b0;
      if (cm_disarm)
      begin
        arm_r  <= 1'b0;
        attn_r <= 1'b0;
        interrupt_enable_latch_r <= 1'b0;
      end
      else if (cm_dis || cm_enb)
      begin
        arm_r  <= 1'b1;
        attn_r <= 1'b1;
        interrupt_enable_latch_r <= cm_enb;
      end
      else if (arm_r && bsy_d_r && !busy_indication)
        attn_r <= 1'b1;
      else if (ack_claim)
        attn_r <= 1'b0;
    end
  end
  // ==========================================================
  // Acknowledge chain
  // Hold stays until the acknowledge is released, so the
  // device number stands for as long as the processor reads
  reg  ack_hold_r;
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      ack_hold_r <= 1'b0;
    else if (CE)
      ack_hold_r <= ack & (ack_claim | ack_hold_r);
  end
  assign ACK_SYNC_N      = ~ack_hold_r;
  assign ACK_CHAIN_OUT_N = ~(ack & ~ack_hold_r & ~ack_claim);
  assign INTERRUPT_REQUEST_N = ~ack_mine;
  // ==========================================================
  // Serial line: transmit, or echo of receive
  assign SERIAL_TRANSMIT_LINE = (write_mode & timing_active_latch_r) ?
                                shift_r[0] :
                                (read_mode_latch_r & ~no_echo_latch_r) ?
                                rxd : 1'b1;
  // ==========================================================
  // Bus read mux
  wire [7:0] status_byte;
  assign status_byte = {off_s, 1'b0, err_r | break_flag_r,
                        busy_indication, 1'b0, break_flag_r, 1'b0, err_r};
  assign BUS_DATA_OE = sel_r & (sr_s | dr_s) | ack_hold_r;
  always @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      BUS_DATA_OUT <= 8'h00;
    else if (CE)
    begin
      if (ack_claim | ack_hold_r)
        BUS_DATA_OUT <= `STP_DEV_NUM;
      else if (sel_r && sr_s)
        BUS_DATA_OUT <= status_byte;
      else if (sel_r && dr_s)
        BUS_DATA_OUT <= byte_buf_r;
      else
        BUS_DATA_OUT <= 8'h00;
    end
  end
endmodule // stp_top

/* File: stp_top_sva.sv */
// Purpose: Port checks for stp_top
// Assumes: Requests held 8 cycles or more
// Notes:   Slack of a few edges for input synchronisers
`timescale 1ns/1ps
module stp_top_sva
(
  input wire       CLK_SYS,
  input wire       RST_N,
  input wire [7:0] BUS_DATA_OUT,
  input wire       BUS_DATA_OE,
  input wire       DATA_REQUEST,
  input wire       STATUS_REQUEST,
  input wire       SERIAL_TRANSMIT_LINE,
  input wire       TERMINAL_OFFLINE,
  input wire       INTERRUPT_REQUEST_N,
  input wire       ACK_CHAIN_IN_N,
  input wire       ACK_CHAIN_OUT_N,
  input wire       ACK_SYNC_N
);
  // ==========
  // Helpers
  reg  [2:0] ack_hist_r;
  wire       stat_on = BUS_DATA_OE && STATUS_REQUEST;
  // Past acknowledge levels, as the chain output lags its input
  always @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
      ack_hist_r <= 3'h7;
    else
      ack_hist_r <= {ack_hist_r[1:0], ACK_CHAIN_IN_N};
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ==========
  // Properties
  property p_reset_idle;
    $rose(RST_N) |-> SERIAL_TRANSMIT_LINE && INTERRUPT_REQUEST_N &&
      ACK_SYNC_N && ACK_CHAIN_OUT_N && !BUS_DATA_OE;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset");
  property p_oe_why;
    $rose(BUS_DATA_OE) |-> STATUS_REQUEST || DATA_REQUEST || !ACK_CHAIN_IN_N;
  endproperty
  a_oe_why: assert property (p_oe_why) else $error("bus drive");
  property p_examine;
    stat_on [*3] |-> BUS_DATA_OUT[5] == (BUS_DATA_OUT[0] | BUS_DATA_OUT[2])
      && {BUS_DATA_OUT[6], BUS_DATA_OUT[3], BUS_DATA_OUT[1]} == 3'h0;
  endproperty
  a_examine: assert property (p_examine) else $error("status");
  property p_unavail;
    stat_on [*3] |-> BUS_DATA_OUT[7] == TERMINAL_OFFLINE;
  endproperty
  a_unavail: assert property (p_unavail) else $error("offline");
  property p_start_low;
    $fell(SERIAL_TRANSMIT_LINE) |-> !SERIAL_TRANSMIT_LINE [*8];
  endproperty
  a_start_low: assert property (p_start_low) else $error("glitch");
  property p_claim_why;
    $fell(ACK_SYNC_N) |-> !ACK_CHAIN_IN_N && !$past(INTERRUPT_REQUEST_N);
  endproperty
  a_claim_why: assert property (p_claim_why) else $error("claim");
  property p_claim_end;
    $fell(ACK_SYNC_N) |-> ##[1:4] INTERRUPT_REQUEST_N;
  endproperty
  a_claim_end: assert property (p_claim_end) else $error("attn");
  property p_pass_why;
    !ACK_CHAIN_OUT_N |-> !ACK_CHAIN_IN_N || ack_hist_r != 3'h7;
  endproperty
  a_pass_why: assert property (p_pass_why) else $error("pass");
  c_claim: cover property ($fell(ACK_SYNC_N));
  c_stat: cover property (stat_on [*3]);
  c_pass: cover property (!ACK_CHAIN_OUT_N);
endmodule // stp_top_sva

/* File: stp_term_model.sv */
// Purpose: Terminal model: keyboard sender, printer receiver
// Assumes: BIT_CYC system clocks per bit
// Notes:   Printer counts only frames whose stop bit is high
`timescale 1ns/1ps
module stp_term_model
#(
  parameter BIT_CYC = 40
)
(
  input  wire clk,
  input  wire tx_line,
  output reg  rx_line
);
  // ==========
  // Keyboard side
  reg [7:0] got_r;
  integer   n_frames;
  integer   i;
  initial rx_line = 1'b1;
  // Start low, data lsb first, two stops; bad drops the stops
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {~bad, ~bad, b, 1'b0};
    for (int k = 0; k < 11; k++)
    begin
      @(posedge clk);
      rx_line <= f[k];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask
  // ==========
  // Printer side, sampled at mid-bit
  initial n_frames = 0;
  always @(negedge tx_line)
  begin
    repeat (BIT_CYC / 2) @(posedge clk);
    for (i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge clk);
      got_r[i] = tx_line;
    end
    repeat (BIT_CYC) @(posedge clk);
    if (tx_line)
      n_frames = n_frames + 1;
  end
endmodule // stp_term_model

/* File: test_serial_terminal_port.sv */
// Purpose: Self-checking bench for stp_top
// Assumes: Short tick counts, 40 clocks per bit
// Notes:   Strobes held 10 cycles to clear the synchronisers
`timescale 1ns/1ps
module test_serial_terminal_port;
  // ==========
  // Signals
  localparam BIT = 40;
  logic        clk_sys, rst_n, b12, b13, offline, ack_in_n, en;
  logic [4:0]  stb;
  logic [7:0]  bus_d, q;
  integer      failures, n_compared;
  wire  [7:0]  data_out;
  wire         oe, tx, rx, irq_n, ack_out_n, sync_n;
  wire  [31:0] frames = i_stp_term_model.n_frames;
  wire  [7:0]  got = i_stp_term_model.got_r;
  stp_top #(.BASE_CYC(10), .FIRST_CYC(20)) i_stp_top (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(1'b1),
    .BUS_DATA_IN(bus_d), .BUS_DATA_OUT(data_out), .BUS_DATA_OE(oe),
    .ADDRESS_STROBE_LINE(stb[0]), .OUTPUT_COMMAND_LINE(stb[1]),
    .DATA_AVAILABLE_STROBE(stb[2]), .DATA_REQUEST(stb[3]),
    .STATUS_REQUEST(stb[4]), .CMD_WRITE_BIT12(b12),
    .CMD_READ_BIT13(b13), .SERIAL_RECEIVE_LINE(rx),
    .SERIAL_TRANSMIT_LINE(tx), .TERMINAL_OFFLINE(offline),
    .INTERRUPT_REQUEST_N(irq_n), .ACK_CHAIN_IN_N(ack_in_n),
    .ACK_CHAIN_OUT_N(ack_out_n), .ACK_SYNC_N(sync_n));
  stp_term_model #(.BIT_CYC(BIT)) i_stp_term_model (
    .clk(clk_sys), .tx_line(tx), .rx_line(rx));
  // ==========
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Byte first, strobe held, bus sampled before release
  task automatic strobe(input int k, input logic [7:0] d);
    @(posedge clk_sys);
    bus_d <= d;
    repeat (3) @(posedge clk_sys);
    stb <= 5'h01 << k;
    repeat (9) @(posedge clk_sys);
    #1;
    q = data_out;
    en = oe;
    @(posedge clk_sys);
    stb <= 5'h00;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] d, input logic w, input logic r);
    @(posedge clk_sys);
    b12 <= w;
    b13 <= r;
    strobe(1, d);
  endtask
  task automatic stat(input logic [7:0] exp);
    strobe(4, 8'h00);
    chk(8'(en), 8'h01);
    chk(q, exp);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // ==========
  // Scenarios
  task automatic t_select;
    strobe(4, 8'h00);
    chk(8'(en), 8'h00);
    strobe(0, 8'h03);
    strobe(4, 8'h00);
    chk(8'(en), 8'h00);
    strobe(0, 8'h02);
    stat(8'h10);
    offline <= 1'b1;
    stat(8'h90);
    offline <= 1'b0;
  endtask
  // Echoed, then blocked; a buffer read brings busy back
  task automatic t_read;
    logic [31:0] n;
    cmd(8'h24, 1'b0, 1'b1);
    n = frames;
    i_stp_term_model.send(8'h3C, 1'b0);
    wait_clk(10);
    chk(got, 8'h3C);
    chk(8'(frames - n), 8'h01);
    stat(8'h00);
    strobe(3, 8'h00);
    chk(q, 8'h3C);
    stat(8'h10);
    cmd(8'h28, 1'b0, 1'b1);
    n = frames;
    i_stp_term_model.send(8'hC5, 1'b0);
    wait_clk(10);
    chk(8'(frames - n), 8'h00);
    strobe(3, 8'h00);
    chk(q, 8'hC5);
  endtask
  // Overrun on an unread byte, then a frame with no stop bits
  task automatic t_faults;
    i_stp_term_model.send(8'h81, 1'b0);
    i_stp_term_model.send(8'h42, 1'b0);
    wait_clk(10);
    stat(8'h21);
    strobe(3, 8'h00);
    cmd(8'h20, 1'b0, 1'b1);
    stat(8'h10);
    i_stp_term_model.send(8'h00, 1'b1);
    wait_clk(2 * BIT);
    strobe(4, 8'h00);
    chk(q & 8'h25, 8'h24);
  endtask
  // Bit period timed on the first data bit, which is high
  task automatic t_write;
    logic [31:0] n;
    int          cnt;
    cmd(8'h10, 1'b1, 1'b0);
    stat(8'h00);
    n = frames;
    strobe(2, 8'hA5);
    for (int c = 0; c < 200 && tx !== 1'b1; c++) @(posedge clk_sys);
    for (cnt = 0; cnt < 99 && tx === 1'b1; cnt++) @(posedge clk_sys);
    chk(8'(cnt), 8'(BIT));
    stat(8'h10);
    for (int c = 0; c < 15 * BIT && frames == n; c++) @(posedge clk_sys);
    chk(got, 8'hA5);
    chk(8'(frames - n), 8'h01);
    wait_clk(2 * BIT);
    stat(8'h00);
    chk(8'(tx), 8'h01);
  endtask
  // Claim while enabled; once disabled the acknowledge passes on
  task automatic t_irq;
    cmd(8'h20, 1'b0, 1'b1);
    strobe(3, 8'h00);
    cmd(8'h02, 1'b0, 1'b0);
    chk(8'(irq_n), 8'h00);
    @(posedge clk_sys);
    ack_in_n <= 1'b0;
    for (int c = 0; c < 20 && sync_n !== 1'b0; c++) @(posedge clk_sys);
    wait_clk(2);
    chk(data_out, 8'h02);
    chk(8'({oe, ack_out_n}), 8'h03);
    @(posedge clk_sys);
    ack_in_n <= 1'b1;
    wait_clk(4);
    chk(8'(irq_n), 8'h01);
    i_stp_term_model.send(8'h11, 1'b0);
    wait_clk(10);
    chk(8'(irq_n), 8'h00);
    cmd(8'h03, 1'b0, 1'b0);
    cmd(8'h01, 1'b0, 1'b0);
    chk(8'(irq_n), 8'h01);
    @(posedge clk_sys);
    ack_in_n <= 1'b0;
    wait_clk(6);
    chk(8'({ack_out_n, sync_n}), 8'h01);
    @(posedge clk_sys);
    ack_in_n <= 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========
  // Clock, sequence and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    failures = 0;
    n_compared = 0;
    {rst_n, bus_d, stb, b12, b13, offline, ack_in_n} = 18'h00001;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_select;
    t_read;
    t_faults;
    t_write;
    t_irq;
    tally_and_finish;
  end
  // Whole run is near 3800 cycles; cut off well beyond
  initial
  begin
    #2000000;
    failures++;
    tally_and_finish;
  end
endmodule // test_serial_terminal_port
bind stp_top stp_top_sva i_stp_top_sva (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .BUS_DATA_OUT(BUS_DATA_OUT),
  .BUS_DATA_OE(BUS_DATA_OE), .DATA_REQUEST(DATA_REQUEST),
  .STATUS_REQUEST(STATUS_REQUEST),
  .SERIAL_TRANSMIT_LINE(SERIAL_TRANSMIT_LINE),
  .TERMINAL_OFFLINE(TERMINAL_OFFLINE),
  .INTERRUPT_REQUEST_N(INTERRUPT_REQUEST_N),
  .ACK_CHAIN_IN_N(ACK_CHAIN_IN_N), .ACK_CHAIN_OUT_N(ACK_CHAIN_OUT_N),
  .ACK_SYNC_N(ACK_SYNC_N));
